// *** tb/fcs_array_model.sv ***
// Purpose: behavioural program memory array facing the sequencer
// Assumes: read data one cycle after the address, commit pulses one cycle long
// Notes: programming only clears bits, as a real cell would
`timescale 1ns/100ps
`default_nettype none
module fcs_array_model (
  input wire logic mclk,
  input wire logic [12:0] arr_addr,
  input wire logic [7:0] arr_wdata,
  input wire logic arr_prog,
  input wire logic arr_erase,
  input wire logic arr_mass,
  output logic [7:0] arr_rdata
);
  logic [7:0] mem [0:8191];
  initial
  begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
    for (int i = 0; i < 8; i++) mem[fcs_pkg::KEY_OFF + 13'(i)] = 8'h10 + 8'(i);
    // key enabled, security field 0:0 so the part comes up secured
    mem[fcs_pkg::NONVOLATILE_OPTION_BYTE_OFF] = 8'h80;
  end
  always @(posedge mclk)
  begin
    arr_rdata <= mem[arr_addr];
    if (arr_prog)
      mem[arr_addr] <= mem[arr_addr] & arr_wdata;
    if (arr_erase)
      for (int i = 0; i < 512; i++) mem[{arr_addr[12:9], 9'(i)}] <= 8'hff;
    if (arr_mass)
      for (int i = 0; i < 8192; i++) mem[i] <= 8'hff;
  end
endmodule : fcs_array_model
`default_nettype wire

// *** tb/fcs_top_properties.sv ***
// Purpose: port-level checks of the command sequencer
// Assumes: bound to every fcs_top instance
// Notes: copy window bound leaves slack over the nominal twelve cycles
`timescale 1ns/100ps
`default_nettype none
module fcs_top_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic secure_exec,
  input wire logic stop_req,
  input wire logic ram_req,
  input wire logic ram_dbg,
  input wire logic [12:0] arr_addr,
  input wire logic arr_hv,
  input wire logic arr_prog,
  input wire logic arr_erase,
  input wire logic arr_mass,
  input wire logic ram_block,
  input wire logic secured
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_commit;
    arr_prog || arr_erase || arr_mass;
  endsequence
  sequence s_copy_prot;
    ##[1:20] (arr_addr == fcs_pkg::NONVOLATILE_PROTECTION_BYTE_OFF);
  endsequence
  sequence s_copy_opt;
    ##[1:20] (arr_addr == fcs_pkg::NONVOLATILE_OPTION_BYTE_OFF);
  endsequence
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_ram_blocked: assert property (
    ram_req && secured && (ram_dbg || !secure_exec) |=> ram_block)
    else $error("ram access not blocked while secured");
  a_ram_open: assert property (ram_req && !secured |=> !ram_block)
    else $error("ram access blocked while unsecured");
  a_commit_onehot: assert property ($onehot0({arr_prog, arr_erase, arr_mass}))
    else $error("two commit pulses at once");
  a_commit_pulse: assert property (s_commit |=> !(arr_prog || arr_erase || arr_mass))
    else $error("commit pulse longer than one cycle");
  a_commit_hv: assert property (s_commit |-> $past(arr_hv) && $past(arr_hv, 3))
    else $error("commit without high voltage");
  a_stop_abort: assert property (stop_req && arr_hv |-> ##[1:3] !arr_hv)
    else $error("stop did not drop high voltage");
  a_reset_secured: assert property ($fell(rst) |-> secured && !arr_hv)
    else $error("not secured after reset");
  a_copy_prot: assert property ($fell(rst) |-> s_copy_prot)
    else $error("protection byte not fetched");
  a_copy_opt: assert property ($fell(rst) |-> s_copy_opt)
    else $error("option byte not fetched");
endmodule : fcs_top_checker
bind fcs_top fcs_top_checker i_fcs_top_checker (.mclk, .rst, .reg_rd, .reg_rdata, .secure_exec,
  .stop_req, .ram_req, .ram_dbg, .arr_addr, .arr_hv, .arr_prog, .arr_erase, .arr_mass,
  .ram_block, .secured);
`default_nettype wire

// *** tb/fcs_top_tb_top.sv ***
// Purpose: self-checking bench for the command sequencer
// Assumes: divider 0x4f gives a 128-cycle command clock (195 kHz)
// Notes: erase counts shortened through parameters
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module fcs_top_tb_top;
  localparam int T = 128;
  localparam int LIM = 6000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reg_dbg = 1'b0, stop_req = 1'b0, ram_req = 1'b0;
  logic secure_exec = 1'b1, ram_dbg = 1'b1;
  logic [7:0] arr_rdata, reg_rdata, arr_wdata, s, p_data;
  logic [12:0] arr_addr, p_addr;
  logic arr_hv, arr_prog, arr_erase, arr_mass, ram_block, secured;
  logic [2:0] kind;
  int fails = 0, compares = 0, cyc = 0, npulse = 0, pulse_at = 0, prev_at = 0, launch;
  fcs_top #(.PAGE_TICKS(15'd5), .MASS_TICKS(15'd7)) i_fcs_top (.mclk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_dbg, .secure_exec, .stop_req, .ram_req, .ram_dbg,
    .arr_rdata, .reg_rdata, .arr_addr, .arr_wdata, .arr_hv, .arr_prog, .arr_erase,
    .arr_mass, .ram_block, .secured);
  fcs_array_model i_fcs_array_model (.mclk, .arr_addr, .arr_wdata, .arr_prog, .arr_erase,
    .arr_mass, .arr_rdata);
  always #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (arr_prog || arr_erase || arr_mass)
    begin
      prev_at <= pulse_at;
      pulse_at <= cyc;
      npulse <= npulse + 1;
      kind <= {arr_mass, arr_erase, arr_prog};
      p_addr <= arr_addr;
      p_data <= arr_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask : bus
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, reg_addr, 8'h00);
  endtask : idle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  // read data is taken at the edge that closes the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    s = reg_rdata;
  endtask : rd
  task automatic poll(input int b);
    int n;
    n = 0;
    rd(fcs_pkg::ADDR_STAT);
    while (s[b] !== 1'b1 && n < LIM)
    begin
      rd(fcs_pkg::ADDR_STAT);
      n++;
    end
    `CHK("status_wait", 1'b1, s[b])
  endtask : poll
  task automatic run(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    wr(a, d);
    wr(fcs_pkg::ADDR_CMD, c);
    wr(fcs_pkg::ADDR_STAT, 8'h80);
    launch = cyc;
  endtask : run
  task automatic fin(input int n, input logic [2:0] k);
    rd(fcs_pkg::ADDR_STAT);
    `CHK("ccf_low", 1'b0, s[6])
    poll(6);
    if (n > 0)
    begin
      `CHK("kind", k, kind)
      `CHK("span", 1'b1, pulse_at - launch > (n - 1) * T && pulse_at - launch <= (n + 1) * T)
    end
  endtask : fin
  task automatic err_chk(input int n0);
    idle(2);
    rd(fcs_pkg::ADDR_STAT);
    `CHK("accerr", 1'b1, s[fcs_pkg::STAT_ACCERR])
    `CHK("no_commit", n0, npulse)
  endtask : err_chk
  task automatic key_entry;
    wr(fcs_pkg::ADDR_CNFG, 8'h20);
    for (int i = 0; i < 8; i++) wr(fcs_pkg::KEY_ADDR + 16'(i), 8'h10 + 8'(i));
    wr(fcs_pkg::ADDR_CNFG, 8'h00);
    idle(3);
  endtask : key_entry
  task automatic ram_try(input logic e);
    ram_req <= 1'b1;
    idle(1);
    ram_req <= 1'b0;
    idle(1);
    `CHK("ram_block", e, ram_block)
  endtask : ram_try
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(fcs_pkg::ADDR_OPT);
    `CHK("opt_copy", 8'h80, s)
    rd(fcs_pkg::ADDR_PROT);
    `CHK("prot_copy", 8'hff, s)
    `CHK("secured", 1'b1, secured)
    $display("test reset done");
  endtask : t_reset
  task automatic t_div;
    wr(16'he000, 8'h00);
    err_chk(npulse);
    wr(fcs_pkg::ADDR_DIV, 8'h4f);
    rd(fcs_pkg::ADDR_DIV);
    `CHK("div_blocked", 8'h00, s)
    wr(fcs_pkg::ADDR_STAT, 8'h10);
    rd(fcs_pkg::ADDR_STAT);
    `CHK("accerr_clear", 1'b0, s[fcs_pkg::STAT_ACCERR])
    wr(fcs_pkg::ADDR_DIV, 8'h4f);
    wr(fcs_pkg::ADDR_DIV, 8'h01);
    rd(fcs_pkg::ADDR_DIV);
    `CHK("div_once", 8'hcf, s)
    $display("test divider done");
  endtask : t_div
  task automatic t_prog;
    run(16'he010, 8'h5a, fcs_pkg::CMD_PROG);
    fin(9, 3'b001);
    run(16'he210, 8'h3c, fcs_pkg::CMD_PROG);
    fin(9, 3'b001);
    `CHK("prog_addr", 13'h0210, p_addr)
    `CHK("prog_data", 8'h3c, p_data)
    `CHK("prog_mem", 8'h5a, i_fcs_array_model.mem[13'h0010])
    $display("test program done");
  endtask : t_prog
  task automatic t_page;
    run(16'he3f7, 8'h00, fcs_pkg::CMD_PAGE);
    fin(5, 3'b010);
    `CHK("page_sel", 4'h1, p_addr[12:9])
    `CHK("page_gone", 8'hff, i_fcs_array_model.mem[13'h0210])
    `CHK("page_keep", 8'h5a, i_fcs_array_model.mem[13'h0010])
    $display("test page erase done");
  endtask : t_page
  task automatic t_burst;
    run(16'he400, 8'h11, fcs_pkg::CMD_BURST);
    poll(7);
    run(16'he401, 8'h22, fcs_pkg::CMD_BURST);
    poll(6);
    `CHK("burst_gap", 1'b1, pulse_at - prev_at > 3 * T && pulse_at - prev_at <= 5 * T)
    `CHK("burst_mem", 8'h22, i_fcs_array_model.mem[13'h0401])
    $display("test burst done");
  endtask : t_burst
  task automatic t_err;
    wr(16'he020, 8'h00);
    wr(fcs_pkg::ADDR_CMD, 8'h33);
    err_chk(npulse);
    wr(fcs_pkg::ADDR_STAT, 8'h10);
    wr(16'he020, 8'h00);
    wr(fcs_pkg::ADDR_CMD, fcs_pkg::CMD_PROG);
    wr(fcs_pkg::ADDR_STAT, 8'h00);
    err_chk(npulse);
    run(16'he020, 8'h77, fcs_pkg::CMD_PROG);
    err_chk(npulse);
    wr(fcs_pkg::ADDR_STAT, 8'h10);
    idle(T * 10);
    `CHK("err_mem", 8'hff, i_fcs_array_model.mem[13'h0020])
    $display("test errors done");
  endtask : t_err
  task automatic t_stop;
    run(16'he030, 8'h44, fcs_pkg::CMD_PROG);
    idle(200);
    stop_req <= 1'b1;
    idle(1);
    stop_req <= 1'b0;
    err_chk(npulse);
    wr(fcs_pkg::ADDR_STAT, 8'h10);
    idle(T * 10);
    `CHK("stop_mem", 8'hff, i_fcs_array_model.mem[13'h0030])
    $display("test stop done");
  endtask : t_stop
  task automatic t_key;
    ram_try(1'b1);
    reg_dbg <= 1'b1;
    key_entry();
    reg_dbg <= 1'b0;
    `CHK("dbg_key", 1'b1, secured)
    wr(fcs_pkg::ADDR_STAT, 8'h10);
    key_entry();
    `CHK("key_open", 1'b0, secured)
    ram_try(1'b0);
    $display("test key done");
  endtask : t_key
  task automatic t_mb;
    rst <= 1'b1;
    idle(10);
    rst <= 1'b0;
    poll(6);
    `CHK("resecured", 1'b1, secured)
    wr(fcs_pkg::ADDR_DIV, 8'h4f);
    run(16'he155, 8'h00, fcs_pkg::CMD_MASS);
    fin(7, 3'b100);
    `CHK("mass_mem", 8'hff, i_fcs_array_model.mem[13'h0400])
    run(16'he777, 8'h00, fcs_pkg::CMD_BLANK);
    fin(0, 3'b000);
    `CHK("blank", 1'b1, s[fcs_pkg::STAT_BLANK])
    `CHK("unsecured", 1'b0, secured)
    $display("test mass blank done");
  endtask : t_mb
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial
  begin
    idle(10);
    rst <= 1'b0;
    poll(6);
    t_reset;
    t_div;
    t_prog;
    t_page;
    t_burst;
    t_err;
    t_stop;
    t_key;
    t_mb;
    print_verdict;
  end
  // expected run is under 25000 cycles
  initial
  begin
    repeat (60000) @(posedge mclk);
    fails++;
    print_verdict;
  end
endmodule : fcs_top_tb_top
`default_nettype wire

// *** verilog/fcs_pkg.sv ***
// Purpose: constants and types for the program memory command sequencer
// Assumes: 8-bit register bus, 16-bit addresses, 8 KiB array at the top of memory
// Notes: counts are in command clock periods unless named otherwise
//
// What this block does
// - The divider register takes one write after reset; later writes are ignored.
// - Divider writes are blocked while the access error flag is set.
// - Program and erase are timed in whole command clock periods.
// - Byte program takes 9 periods; a chained burst byte takes 4.
// - Page erase takes 4000 periods; mass erase takes 20000.
// - A command opens with an array write whose address and data are latched.
// - Page erase takes any address in its page; mass erase and blank check any.
// - Erase unit is a 512-byte page; the array is 16 such pages.
// - Codes 0x05 blank check, 0x20 byte program, 0x25 burst are decoded.
// - Codes 0x40 page erase, 0x41 mass erase; no other code is valid.
// - Writing one to the buffer-empty flag launches and clears that flag.
// - Writing zero to it mid-sequence aborts and sets the access error flag.
// - No new command is taken while the access error flag is set.
// - A command-complete flag shows when the launched command has finished.
// - Each reset copies protection and option bytes into working registers.
// - With key enable set, a matching 8-byte key lifts security until reset.
// - Key entry only from secure code, never from the debug port.
// - With the key off, only mass erase plus passing blank check unsecures.
// - Security field value 1:0 means unsecured.
// - While secured, RAM access from debug or non-secure code is blocked.
// - Access error clears only by writing one; no command launches while set.
// - An array write while the buffer-empty flag is clear is an access error.
// - Stop mode during program or erase aborts it and sets access error.
package fcs_pkg;
  localparam logic [15:0] ADDR_DIV = 16'h1820;
  localparam logic [15:0] ADDR_OPT = 16'h1821;
  localparam logic [15:0] ADDR_CNFG = 16'h1823;
  localparam logic [15:0] ADDR_PROT = 16'h1824;
  localparam logic [15:0] ADDR_STAT = 16'h1825;
  localparam logic [15:0] ADDR_CMD = 16'h1826;
  localparam logic [15:0] ARRAY_BASE = 16'he000;
  localparam logic [15:0] KEY_ADDR = 16'hffb0;
  localparam logic [15:0] NONVOLATILE_PROTECTION_BYTE_ADDR = 16'hffbd;
  localparam logic [15:0] NONVOLATILE_OPTION_BYTE_ADDR = 16'hffbf;
  localparam logic [12:0] KEY_OFF = 13'(KEY_ADDR - ARRAY_BASE);
  localparam logic [12:0] NONVOLATILE_PROTECTION_BYTE_OFF = 13'(NONVOLATILE_PROTECTION_BYTE_ADDR - ARRAY_BASE);
  localparam logic [12:0] NONVOLATILE_OPTION_BYTE_OFF = 13'(NONVOLATILE_OPTION_BYTE_ADDR - ARRAY_BASE);
  localparam logic [13:0] ARRAY_BYTES = 14'h2000;
  localparam logic [13:0] LOAD_LEN = 14'h000a;
  localparam logic [8:0] PAGE_MASK = 9'h1ff;
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_PROG = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  localparam logic [7:0] ERASED = 8'hff;
  localparam int STAT_CBEF = 7;
  localparam int STAT_CCF = 6;
  localparam int STAT_PVIOL = 5;
  localparam int STAT_ACCERR = 4;
  localparam int STAT_BLANK = 2;
  localparam int DIV_LOADED = 7;
  localparam int DIV_PRE8 = 6;
  localparam int CNFG_KEYACC = 5;
  localparam int OPT_KEY_ENABLE_BIT = 7;
  localparam logic [1:0] SEC_OPEN = 2'h2;
  localparam logic [2:0] PRE8_LAST = 3'h7;
  localparam logic [14:0] PROG_TICKS = 15'd9;
  localparam logic [14:0] BURST_TICKS = 15'd4;
  localparam logic [14:0] PAGE_TICKS = 15'd4000;
  localparam logic [14:0] MASS_TICKS = 15'd20000;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] PROT_RST = 8'hff;
  localparam logic [7:0] OPT_RST = 8'h00;
  typedef enum logic [1:0] {FCS_LOAD, FCS_IDLE, FCS_RUN, FCS_BLANK} fcs_state_t;
  typedef enum logic [1:0] {SEQ_EMPTY, SEQ_ADDR, SEQ_CMD} fcs_seq_t;
endpackage : fcs_pkg

// *** verilog/fcs_top.sv ***
// Purpose: command sequencer for the on-chip program memory array
// Assumes: array macro outside answers arr_rdata one cycle after arr_addr
// Notes: the array applies a program or erase on the one-cycle commit pulses
`timescale 1ns/100ps
`default_nettype none
module fcs_top #(
  parameter logic [14:0] PAGE_TICKS = fcs_pkg::PAGE_TICKS,
  parameter logic [14:0] MASS_TICKS = fcs_pkg::MASS_TICKS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_dbg,
  input wire logic secure_exec,
  input wire logic stop_req,
  input wire logic ram_req,
  input wire logic ram_dbg,
  input wire logic [7:0] arr_rdata,
  output logic [7:0] reg_rdata,
  output logic [12:0] arr_addr,
  output logic [7:0] arr_wdata,
  output logic arr_hv,
  output logic arr_prog,
  output logic arr_erase,
  output logic arr_mass,
  output logic ram_block,
  output logic secured
);
  fcs_pkg::fcs_state_t st_q;
  fcs_pkg::fcs_seq_t seq_q;
  logic [7:0] div_q;
  logic [7:0] prot_q;
  logic [7:0] opt_q;
  logic keyacc_q;
  logic [63:0] key_q;
  logic [63:0] entry_q;
  logic [7:0] seen_q;
  logic [2:0] pre_q;
  logic [5:0] divc_q;
  logic tick_q;
  logic [12:0] buf_addr_q;
  logic [7:0] buf_data_q;
  logic [7:0] buf_cmd_q;
  logic pending_q;
  logic [12:0] ex_addr_q;
  logic [7:0] ex_data_q;
  logic [7:0] ex_cmd_q;
  logic [14:0] cnt_q;
  logic [13:0] scan_q;
  logic chk_q;
  logic blank_ok_q;
  logic cbef_q;
  logic ccf_q;
  logic pviol_q;
  logic accerr_q;
  logic blank_q;
  logic unlock_q;
  logic erased_q;

  logic wr_arr, wr_div, wr_opt, wr_cnfg, wr_prot, wr_stat, wr_cmd;
  logic key_wr, cmd_arr, cmd_ok, dbg_bad, seq_err, launch, prot_hit, go;
  logic done_now, fast, start, blank_done, sec_now, key_match, is_prog;
  logic [15:0] last_open;
  logic [3:0] cap_idx;
  logic [12:0] ld_off;

  //////////////////////////////////////////////////////////////////////
  // decode and sequence checks
  always_comb
  begin
    wr_arr = reg_wr && (reg_addr >= fcs_pkg::ARRAY_BASE);
    wr_div = reg_wr && (reg_addr == fcs_pkg::ADDR_DIV);
    wr_opt = reg_wr && (reg_addr == fcs_pkg::ADDR_OPT);
    wr_cnfg = reg_wr && (reg_addr == fcs_pkg::ADDR_CNFG);
    wr_prot = reg_wr && (reg_addr == fcs_pkg::ADDR_PROT);
    wr_stat = reg_wr && (reg_addr == fcs_pkg::ADDR_STAT);
    wr_cmd = reg_wr && (reg_addr == fcs_pkg::ADDR_CMD);
    // key bytes go to the entry buffer, never to the command path
    key_wr = wr_arr && keyacc_q && !reg_dbg && secure_exec
      && (reg_addr[15:3] == fcs_pkg::KEY_ADDR[15:3]);
    cmd_arr = wr_arr && !key_wr;
    cmd_ok = (reg_wdata == fcs_pkg::CMD_BLANK) || (reg_wdata == fcs_pkg::CMD_PROG)
      || (reg_wdata == fcs_pkg::CMD_BURST)
      || (reg_wdata == fcs_pkg::CMD_PAGE) || (reg_wdata == fcs_pkg::CMD_MASS);
    sec_now = (opt_q[1:0] != fcs_pkg::SEC_OPEN) && !unlock_q;
    // a secured debug port may only blank check or mass erase
    dbg_bad = reg_dbg && sec_now && ((reg_wdata == fcs_pkg::CMD_PROG)
      || (reg_wdata == fcs_pkg::CMD_BURST) || (reg_wdata == fcs_pkg::CMD_PAGE));
    seq_err = (cmd_arr && (!div_q[fcs_pkg::DIV_LOADED] || !cbef_q
        || (seq_q != fcs_pkg::SEQ_EMPTY)))
      || (wr_cmd && ((seq_q != fcs_pkg::SEQ_ADDR) || !cmd_ok || dbg_bad))
      || ((wr_div || wr_cnfg || wr_prot || wr_opt) && (seq_q != fcs_pkg::SEQ_EMPTY))
      || (wr_stat && (seq_q == fcs_pkg::SEQ_ADDR))
      || (wr_stat && (seq_q == fcs_pkg::SEQ_CMD) && !reg_wdata[fcs_pkg::STAT_CBEF])
      || (stop_req && (st_q == fcs_pkg::FCS_RUN));
    launch = wr_stat && (seq_q == fcs_pkg::SEQ_CMD) && reg_wdata[fcs_pkg::STAT_CBEF]
      && !accerr_q && !pviol_q;
    last_open = {prot_q[7:1], fcs_pkg::PAGE_MASK};
    is_prog = (buf_cmd_q == fcs_pkg::CMD_PROG) || (buf_cmd_q == fcs_pkg::CMD_BURST);
    prot_hit = !prot_q[0] && ((buf_cmd_q == fcs_pkg::CMD_MASS)
      || ((is_prog || (buf_cmd_q == fcs_pkg::CMD_PAGE))
      && ({3'h7, buf_addr_q} > last_open)));
    go = launch && !prot_hit;
    done_now = (st_q == fcs_pkg::FCS_RUN) && tick_q && (cnt_q == 15'd1);
    // high voltage stays up only for the next byte of the same 64-byte row
    fast = done_now && pending_q && (ex_cmd_q == fcs_pkg::CMD_BURST)
      && (buf_cmd_q == fcs_pkg::CMD_BURST)
      && (buf_addr_q == 13'(ex_addr_q + 13'd1)) && (buf_addr_q[5:0] != 6'h00);
    start = pending_q && ((st_q == fcs_pkg::FCS_IDLE) || fast);
    blank_done = (st_q == fcs_pkg::FCS_BLANK) && (scan_q > fcs_pkg::ARRAY_BYTES)
      && !chk_q;
    key_match = wr_cnfg && keyacc_q && !reg_wdata[fcs_pkg::CNFG_KEYACC]
      && (seen_q == 8'hff) && opt_q[fcs_pkg::OPT_KEY_ENABLE_BIT] && (entry_q == key_q);
    cap_idx = 4'(scan_q - 14'd2);
    if (scan_q[3:0] < 4'h8)
      ld_off = fcs_pkg::KEY_OFF + {10'h000, scan_q[2:0]};
    else if (scan_q[3:0] == 4'h8)
      ld_off = fcs_pkg::NONVOLATILE_PROTECTION_BYTE_OFF;
    else
      ld_off = fcs_pkg::NONVOLATILE_OPTION_BYTE_OFF;
  end

  //////////////////////////////////////////////////////////////////////
  // command clock: one enable pulse per period of (div+1) * (8 or 1)
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pre_q <= '0;
      divc_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (div_q[fcs_pkg::DIV_LOADED])
      begin
        if (div_q[fcs_pkg::DIV_PRE8] && (pre_q != fcs_pkg::PRE8_LAST))
          pre_q <= pre_q + 3'd1;
        else
        begin
          pre_q <= '0;
          if (divc_q == div_q[5:0])
          begin
            divc_q <= '0;
            tick_q <= 1'b1;
          end
          else
            divc_q <= divc_q + 6'd1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // configuration, working copies and key entry
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      div_q <= fcs_pkg::DIV_RST;
      prot_q <= fcs_pkg::PROT_RST;
      opt_q <= fcs_pkg::OPT_RST;
      keyacc_q <= 1'b0;
      key_q <= '0;
      entry_q <= '0;
      seen_q <= '0;
    end
    else
    begin
      if (wr_div && !div_q[fcs_pkg::DIV_LOADED] && !accerr_q
          && (seq_q == fcs_pkg::SEQ_EMPTY))
        div_q <= {1'b1, reg_wdata[6:0]};
      if ((st_q == fcs_pkg::FCS_LOAD) && chk_q)
      begin
        if (cap_idx < 4'h8)
          key_q[8 * (7 - cap_idx[2:0]) +: 8] <= arr_rdata;
        else if (cap_idx == 4'h8)
          prot_q <= arr_rdata;
        else
          opt_q <= arr_rdata;
      end
      // protection can be rewritten only from the debug port
      else if (wr_prot && reg_dbg && (seq_q == fcs_pkg::SEQ_EMPTY))
        prot_q <= reg_wdata;
      if (wr_cnfg && (seq_q == fcs_pkg::SEQ_EMPTY))
      begin
        if (!reg_wdata[fcs_pkg::CNFG_KEYACC])
          keyacc_q <= 1'b0;
        else if (secure_exec && !reg_dbg)
        begin
          keyacc_q <= 1'b1;
          seen_q <= '0;
        end
      end
      if (key_wr)
      begin
        entry_q[8 * (7 - reg_addr[2:0]) +: 8] <= reg_wdata;
        seen_q[reg_addr[2:0]] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // command buffer: array write, code, launch
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      seq_q <= fcs_pkg::SEQ_EMPTY;
      buf_addr_q <= '0;
      buf_data_q <= '0;
      buf_cmd_q <= '0;
      pending_q <= 1'b0;
    end
    else
    begin
      if (start)
        pending_q <= 1'b0;
      if (accerr_q || seq_err)
        seq_q <= fcs_pkg::SEQ_EMPTY;
      else if (cmd_arr && (seq_q == fcs_pkg::SEQ_EMPTY))
      begin
        buf_addr_q <= reg_addr[12:0];
        buf_data_q <= reg_wdata;
        seq_q <= fcs_pkg::SEQ_ADDR;
      end
      else if (wr_cmd)
      begin
        buf_cmd_q <= reg_wdata;
        seq_q <= fcs_pkg::SEQ_CMD;
      end
      else if (launch)
      begin
        seq_q <= fcs_pkg::SEQ_EMPTY;
        if (!prot_hit)
          pending_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // execution: reset copy, timed pulses, blank scan
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= fcs_pkg::FCS_LOAD;
      cnt_q <= '0;
      ex_addr_q <= '0;
      ex_data_q <= '0;
      ex_cmd_q <= '0;
      scan_q <= '0;
      chk_q <= 1'b0;
      blank_ok_q <= 1'b1;
    end
    else
    begin
      case (st_q)
        fcs_pkg::FCS_LOAD:
        begin
          chk_q <= (scan_q != '0) && (scan_q <= fcs_pkg::LOAD_LEN);
          if (scan_q <= fcs_pkg::LOAD_LEN)
            scan_q <= scan_q + 14'd1;
          else if (!chk_q)
          begin
            st_q <= fcs_pkg::FCS_IDLE;
            scan_q <= '0;
          end
        end
        fcs_pkg::FCS_BLANK:
        begin
          chk_q <= (scan_q != '0) && (scan_q <= fcs_pkg::ARRAY_BYTES);
          if (chk_q && (arr_rdata != fcs_pkg::ERASED))
            blank_ok_q <= 1'b0;
          if (scan_q <= fcs_pkg::ARRAY_BYTES)
            scan_q <= scan_q + 14'd1;
          else if (!chk_q)
            st_q <= fcs_pkg::FCS_IDLE;
        end
        fcs_pkg::FCS_RUN:
        begin
          if (stop_req)
            st_q <= fcs_pkg::FCS_IDLE;
          else if (tick_q)
          begin
            cnt_q <= cnt_q - 15'd1;
            if (cnt_q == 15'd1)
              st_q <= fcs_pkg::FCS_IDLE;
          end
        end
        default:
        begin
        end
      endcase
      if (start)
      begin
        ex_addr_q <= buf_addr_q;
        ex_data_q <= buf_data_q;
        ex_cmd_q <= buf_cmd_q;
        scan_q <= '0;
        chk_q <= 1'b0;
        blank_ok_q <= 1'b1;
        if (buf_cmd_q == fcs_pkg::CMD_BLANK)
          st_q <= fcs_pkg::FCS_BLANK;
        else
          st_q <= fcs_pkg::FCS_RUN;
        if (buf_cmd_q == fcs_pkg::CMD_PAGE)
          cnt_q <= PAGE_TICKS;
        else if (buf_cmd_q == fcs_pkg::CMD_MASS)
          cnt_q <= MASS_TICKS;
        else if (fast)
          cnt_q <= fcs_pkg::BURST_TICKS;
        else
          cnt_q <= fcs_pkg::PROG_TICKS;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // array port
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      arr_addr <= '0;
      arr_wdata <= '0;
      arr_hv <= 1'b0;
      arr_prog <= 1'b0;
      arr_erase <= 1'b0;
      arr_mass <= 1'b0;
    end
    else
    begin
      if (st_q == fcs_pkg::FCS_LOAD)
        arr_addr <= ld_off;
      else if (st_q == fcs_pkg::FCS_BLANK)
        arr_addr <= scan_q[12:0];
      else
        arr_addr <= ex_addr_q;
      arr_wdata <= ex_data_q;
      arr_hv <= (st_q == fcs_pkg::FCS_RUN) && !stop_req;
      arr_prog <= done_now && !stop_req && ((ex_cmd_q == fcs_pkg::CMD_PROG)
        || (ex_cmd_q == fcs_pkg::CMD_BURST));
      // page erase ignores the low nine address bits
      arr_erase <= done_now && !stop_req && (ex_cmd_q == fcs_pkg::CMD_PAGE);
      arr_mass <= done_now && !stop_req && (ex_cmd_q == fcs_pkg::CMD_MASS);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status flags; a hardware set wins over a software clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cbef_q <= 1'b1;
      ccf_q <= 1'b0;
      pviol_q <= 1'b0;
      accerr_q <= 1'b0;
      blank_q <= 1'b0;
    end
    else
    begin
      if (go)
        cbef_q <= 1'b0;
      else if (start)
        cbef_q <= 1'b1;
      ccf_q <= !go && !pending_q && (st_q == fcs_pkg::FCS_IDLE);
      accerr_q <= seq_err || (accerr_q
        && !(wr_stat && reg_wdata[fcs_pkg::STAT_ACCERR]));
      pviol_q <= (launch && prot_hit) || (pviol_q
        && !(wr_stat && reg_wdata[fcs_pkg::STAT_PVIOL]));
      if (go)
        blank_q <= 1'b0;
      else if (blank_done && blank_ok_q)
        blank_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // security
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      unlock_q <= 1'b0;
      erased_q <= 1'b0;
      secured <= 1'b1;
      ram_block <= 1'b0;
    end
    else
    begin
      if (arr_mass)
        erased_q <= 1'b1;
      else if (arr_prog)
        erased_q <= 1'b0;
      if (key_match)
        unlock_q <= 1'b1;
      else if (blank_done && blank_ok_q && erased_q)
        unlock_q <= 1'b1;
      secured <= sec_now;
      ram_block <= secured && ram_req && (ram_dbg || !secure_exec);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register read, data in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else if (reg_addr == fcs_pkg::ADDR_DIV)
      reg_rdata <= div_q;
    else if (reg_addr == fcs_pkg::ADDR_OPT)
      reg_rdata <= opt_q;
    else if (reg_addr == fcs_pkg::ADDR_CNFG)
      reg_rdata <= {2'b00, keyacc_q, 5'b00000};
    else if (reg_addr == fcs_pkg::ADDR_PROT)
      reg_rdata <= prot_q;
    else if (reg_addr == fcs_pkg::ADDR_STAT)
      reg_rdata <= {cbef_q, ccf_q, pviol_q, accerr_q, 1'b0, blank_q, 2'b00};
    else if (reg_addr == fcs_pkg::ADDR_CMD)
      reg_rdata <= buf_cmd_q;
    else
      reg_rdata <= '0;
  end
endmodule : fcs_top
`default_nettype wire
